// ### mpc_pkg.sv
package mpc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 15;
  localparam int NUM_CH = 6;
  localparam int NUM_PAIR = 3;
  localparam int NUM_FAULT = 6;
  localparam int DT_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LOAD = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_FAULT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OUTCTL = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_SWOUT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0a;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DEADTIME = 8'h0e;
  localparam logic [ADDR_W-1:0] OFS_MOD0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ICCTL = 8'h1e;
  localparam logic [ADDR_W-1:0] OFS_VAL0 = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CNT0 = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_STEP = 8'h02;
  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_COMP = 1;
  localparam int CTRL_CENTER = 2;
  localparam int CTRL_CE = 3;
  localparam int CTRL_GSEL = 4;
  localparam int CTRL_IPOL = 7;
  localparam int CTRL_ISENS = 10;
  localparam logic [10:0] CTRL_RST = 11'h000;
  // correction control fields
  localparam int ICC_LSB = 0;
  localparam int PEC_LSB = 3;
  localparam logic [5:0] ICCTL_RST = 6'h00;
  // fault register: enables in [5:0], force levels in [13:8]
  localparam int FLT_LVL_LSB = 8;
  localparam logic [CNT_W-1:0] MOD_RST = 15'h00ff;
  localparam logic [DT_W-1:0] DT_RST = 8'h00;
endpackage

// ### mpc_sync.sv
module mpc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d_async,
  input wire logic [WIDTH-1:0] rst_val,
  output logic [WIDTH-1:0] q_sync
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_chk
    $error("mpc_sync width must be positive");
  end

  // two flops; the first is read only by the second
  always_ff @(posedge CLOCK) begin
    // both stages start at the idle level of their line, so no false change follows reset
    if (RESET) begin
      meta_r <= rst_val;
      q_sync <= rst_val;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end
endmodule

// ### mpc_timebase.sv
module mpc_timebase #(
  parameter int CNT_W = 15
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // configuration
  input wire logic [CNT_W-1:0] modulus,
  input wire logic center,
  // time base state
  output logic [CNT_W-1:0] count_r,
  output logic down_r,
  output logic cycle_start_r
);
  if (CNT_W < 2) begin : g_chk
    $error("mpc_timebase counter too narrow");
  end

  // edge-aligned counts up and wraps; center-aligned counts up then down
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      count_r <= '0;
      down_r <= 1'b0;
      cycle_start_r <= 1'b0;
    end else if (!center) begin
      down_r <= 1'b0;
      cycle_start_r <= (count_r >= modulus);
      count_r <= (count_r >= modulus) ? '0 : count_r + 1'b1;
    end else if (!down_r) begin
      cycle_start_r <= 1'b0;
      if (count_r >= modulus) begin
        down_r <= 1'b1;
        count_r <= count_r - 1'b1;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end else begin
      // bottom of the triangle opens a new load cycle
      cycle_start_r <= (count_r == '0);
      if (count_r == '0) begin
        down_r <= 1'b0;
        count_r <= count_r + 1'b1;
      end else begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ### mpc_motor_pwm.sv
module mpc_motor_pwm
  import mpc_pkg::*;
#(
  parameter int NUM_CH_P = mpc_pkg::NUM_CH
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // register port
  input wire logic [mpc_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [mpc_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [mpc_pkg::DATA_W-1:0] REG_RDATA,
  // fault and current status inputs
  input wire logic [mpc_pkg::NUM_FAULT-1:0] FAULT,
  input wire logic [mpc_pkg::NUM_PAIR-1:0] CURRENT_STATUS_N,
  // integration-level events
  input wire logic GLOBAL_LOAD_OK,
  input wire logic COMMUTATION_EVENT,
  // pwm channel outputs
  output logic [mpc_pkg::NUM_CH-1:0] PWM_OUT
);
  import mpc_pkg::*;

  if (NUM_CH_P != NUM_CH) begin : g_chk
    $error("mpc_motor_pwm supports exactly six channels");
  end

  // register field widths and the fault split, so the logic carries no bare field numbers
  localparam int CTRL_W = CTRL_ISENS + 1;
  localparam int FCFG_W = FLT_LVL_LSB + NUM_CH;
  localparam int ICCTL_W = PEC_LSB + NUM_PAIR;
  localparam int NUM_DIS = 4; // faults below this index blank, the rest force a level

  // every register must fit the data word of the register port
  if (FCFG_W > DATA_W || CNT_W > DATA_W) begin : g_chk_w
    $error("mpc_motor_pwm registers wider than the data word");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int SYNC_W = NUM_FAULT + NUM_PAIR + 2;
  logic [SYNC_W-1:0] sync_q;
  logic [NUM_FAULT-1:0] fault_s;
  logic [NUM_PAIR-1:0] cs_n_s;
  logic glb_ldok_s;
  logic event_s;
  logic event_d_r;
  logic event_pulse;

  // current status idles high, so its reset value is inverted in
  mpc_sync #(.WIDTH(SYNC_W)) u_sync (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .d_async({COMMUTATION_EVENT, GLOBAL_LOAD_OK, CURRENT_STATUS_N, FAULT}),
    .rst_val({2'b00, {NUM_PAIR{1'b1}}, {NUM_FAULT{1'b0}}}),
    .q_sync(sync_q)
  );

  assign fault_s = sync_q[NUM_FAULT-1:0];
  assign cs_n_s = sync_q[NUM_FAULT +: NUM_PAIR];
  assign glb_ldok_s = sync_q[NUM_FAULT+NUM_PAIR];
  assign event_s = sync_q[NUM_FAULT+NUM_PAIR+1];

  // rising edge of the synchronised commutation event
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      event_d_r <= 1'b0;
    end else begin
      event_d_r <= event_s;
    end
  end
  assign event_pulse = event_s & ~event_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [CTRL_W-1:0] ctrl_r;
  logic [NUM_PAIR-1:0] ldok_r;
  logic [FCFG_W-1:0] fault_cfg_r;
  logic [NUM_CH-1:0] outctl_buf_r, swout_buf_r, mask_buf_r;
  logic [NUM_CH-1:0] outctl_r, swout_r, mask_r;
  logic [DT_W-1:0] deadtime_r;
  logic [CNT_W-1:0] mod_r [NUM_PAIR];
  logic [CNT_W-1:0] val_buf_r [NUM_CH];
  logic [CNT_W-1:0] val_r [NUM_CH];
  logic [ICCTL_W-1:0] icctl_buf_r;
  logic [NUM_PAIR-1:0] icc_r, pec_r;

  // decode of one register slot in a group of equally spaced registers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base, input int idx);
    hit = (a == base + ADDR_W'(idx) * OFS_STEP);
  endfunction

  logic wr_ctrl, wr_load, wr_fault, wr_outctl, wr_swout, wr_mask, wr_dt, wr_icctl;
  assign wr_ctrl = REG_WR & (REG_ADDR == OFS_CTRL);
  assign wr_load = REG_WR & (REG_ADDR == OFS_LOAD);
  assign wr_fault = REG_WR & (REG_ADDR == OFS_FAULT);
  assign wr_outctl = REG_WR & (REG_ADDR == OFS_OUTCTL);
  assign wr_swout = REG_WR & (REG_ADDR == OFS_SWOUT);
  assign wr_mask = REG_WR & (REG_ADDR == OFS_MASK);
  assign wr_dt = REG_WR & (REG_ADDR == OFS_DEADTIME);
  assign wr_icctl = REG_WR & (REG_ADDR == OFS_ICCTL);

  // plain configuration registers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ctrl_r <= CTRL_RST;
      fault_cfg_r <= '0;
      deadtime_r <= DT_RST;
      icctl_buf_r <= ICCTL_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= REG_WDATA[CTRL_W-1:0];
      if (wr_fault) fault_cfg_r <= REG_WDATA[FCFG_W-1:0];
      if (wr_dt) deadtime_r <= REG_WDATA[DT_W-1:0];
      if (wr_icctl) icctl_buf_r <= REG_WDATA[ICCTL_W-1:0];
    end
  end

  // modulus and value buffers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      for (int p = 0; p < NUM_PAIR; p++) mod_r[p] <= MOD_RST;
      for (int c = 0; c < NUM_CH; c++) val_buf_r[c] <= '0;
    end else if (REG_WR) begin
      for (int p = 0; p < NUM_PAIR; p++) if (hit(REG_ADDR, OFS_MOD0, p)) mod_r[p] <= REG_WDATA[CNT_W-1:0];
      for (int c = 0; c < NUM_CH; c++) if (hit(REG_ADDR, OFS_VAL0, c)) val_buf_r[c] <= REG_WDATA[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time bases
  logic [CNT_W-1:0] cnt [NUM_PAIR];
  logic [NUM_PAIR-1:0] down, cyc_start;

  for (genvar p = 0; p < NUM_PAIR; p++) begin : g_tb
    mpc_timebase #(.CNT_W(CNT_W)) u_tb (
      .CLOCK(CLOCK),
      .RESET(RESET),
      .modulus(mod_r[p]),
      .center(ctrl_r[CTRL_CENTER]),
      .count_r(cnt[p]),
      .down_r(down[p]),
      .cycle_start_r(cyc_start[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // load permits and buffered loads
  logic [NUM_PAIR-1:0] permit;
  assign permit = ldok_r | (ctrl_r[CTRL_GSEL +: NUM_PAIR] & {NUM_PAIR{glb_ldok_s}});

  // set wins over the clear made by the load itself
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ldok_r <= '0;
    end else begin
      for (int p = 0; p < NUM_PAIR; p++) begin
        if (wr_load & REG_WDATA[p]) ldok_r[p] <= 1'b1;
        else if (cyc_start[p] & ldok_r[p]) ldok_r[p] <= 1'b0;
      end
    end
  end

  // correction source reloads every cycle; edge control and values wait for a permit
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      icc_r <= '0;
      pec_r <= '0;
      for (int c = 0; c < NUM_CH; c++) val_r[c] <= '0;
    end else begin
      for (int p = 0; p < NUM_PAIR; p++) begin
        if (cyc_start[p]) icc_r[p] <= icctl_buf_r[ICC_LSB+p];
        if (cyc_start[p] & permit[p]) begin
          pec_r[p] <= icctl_buf_r[PEC_LSB+p];
          val_r[2*p] <= val_buf_r[2*p];
          val_r[2*p+1] <= val_buf_r[2*p+1];
        end
      end
    end
  end

  // output control, software output and mask: direct or commutation-buffered
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      outctl_buf_r <= '0;
      swout_buf_r <= '0;
      mask_buf_r <= '0;
      outctl_r <= '0;
      swout_r <= '0;
      mask_r <= '0;
    end else begin
      if (wr_outctl) outctl_buf_r <= REG_WDATA[NUM_CH-1:0];
      if (wr_swout) swout_buf_r <= REG_WDATA[NUM_CH-1:0];
      if (wr_mask) mask_buf_r <= REG_WDATA[NUM_CH-1:0];
      if (!ctrl_r[CTRL_CE] || event_pulse) begin
        outctl_r <= outctl_buf_r;
        swout_r <= swout_buf_r;
        mask_r <= mask_buf_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse generation per pair
  logic [NUM_PAIR-1:0] raw, raw_prev_r, corr_sel_r;
  logic [NUM_PAIR-1:0] dt_busy;
  logic [DT_W-1:0] dt_cnt_r [NUM_PAIR];
  logic [NUM_CH-1:0] gen;

  // value register choice and pulse for one pair
  always_comb begin
    for (int p = 0; p < NUM_PAIR; p++) begin
      logic use_odd;
      use_odd = 1'b0;
      if (pec_r[p]) begin
        // one value opens the pulse, the other closes it
        raw[p] = (cnt[p] >= val_r[2*p]) & (cnt[p] < val_r[2*p+1]);
      end else begin
        if (ctrl_r[CTRL_COMP] && ctrl_r[CTRL_ISENS]) begin
          use_odd = corr_sel_r[p];
        end else if (ctrl_r[CTRL_COMP] && ctrl_r[CTRL_CENTER]) begin
          use_odd = icc_r[p] ? ctrl_r[CTRL_IPOL+p] : down[p];
        end
        raw[p] = cnt[p] < (use_odd ? val_r[2*p+1] : val_r[2*p]);
      end
    end
  end

  // the switching cycle is already dead, else one switch turns on as the other turns off
  always_comb begin
    for (int p = 0; p < NUM_PAIR; p++) begin
      dt_busy[p] = ((raw[p] != raw_prev_r[p]) && (deadtime_r != '0)) || (dt_cnt_r[p] != '0);
    end
  end

  // deadtime insertion and sampling of the current status while it runs
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      raw_prev_r <= '0;
      corr_sel_r <= '0;
      for (int p = 0; p < NUM_PAIR; p++) dt_cnt_r[p] <= '0;
    end else begin
      raw_prev_r <= raw;
      for (int p = 0; p < NUM_PAIR; p++) begin
        // the counter holds one cycle less, since the switching cycle counts as dead
        if ((raw[p] != raw_prev_r[p]) && (deadtime_r != '0)) dt_cnt_r[p] <= deadtime_r - 1'b1;
        else if (dt_cnt_r[p] != '0) dt_cnt_r[p] <= dt_cnt_r[p] - 1'b1;
        // low status means current flows out: bottom correction
        if (dt_busy[p]) corr_sel_r[p] <= ~cs_n_s[p];
      end
    end
  end

  // complementary or independent channel waveforms
  always_comb begin
    for (int p = 0; p < NUM_PAIR; p++) begin
      if (ctrl_r[CTRL_COMP]) begin
        gen[2*p] = raw[p] & ~dt_busy[p];
        gen[2*p+1] = ~raw[p] & ~dt_busy[p];
      end else begin
        gen[2*p] = cnt[p] < val_r[2*p];
        gen[2*p+1] = cnt[p] < val_r[2*p+1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stage: software override, mask, faults
  logic [NUM_CH-1:0] out_nxt;
  logic dis_fault, force_fault;

  // faults 0-3 shut outputs off; faults 4-5 drive the configured levels
  assign dis_fault = |(fault_s[NUM_DIS-1:0] & fault_cfg_r[NUM_DIS-1:0]);
  assign force_fault = |(fault_s[NUM_FAULT-1:NUM_DIS] & fault_cfg_r[NUM_FAULT-1:NUM_DIS]);

  always_comb begin
    out_nxt = (outctl_r & swout_r) | (~outctl_r & gen);
    out_nxt = out_nxt & ~mask_r;
    if (!ctrl_r[CTRL_EN]) out_nxt = '0;
    if (dis_fault) out_nxt = '0;
    if (force_fault) out_nxt = fault_cfg_r[FLT_LVL_LSB +: NUM_CH];
  end

  // registered outputs keep glitches from the gate drive
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      PWM_OUT <= '0;
    end else begin
      PWM_OUT <= out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [DATA_W-1:0] rd_nxt;

  // buffers are returned, not the values in use
  always_comb begin
    rd_nxt = '0;
    case (REG_ADDR)
      OFS_CTRL: rd_nxt = DATA_W'(ctrl_r);
      OFS_LOAD: rd_nxt = DATA_W'(ldok_r);
      OFS_FAULT: rd_nxt = DATA_W'(fault_cfg_r);
      OFS_OUTCTL: rd_nxt = DATA_W'(outctl_buf_r);
      OFS_SWOUT: rd_nxt = DATA_W'(swout_buf_r);
      OFS_MASK: rd_nxt = DATA_W'(mask_buf_r);
      OFS_STATUS: rd_nxt = DATA_W'({down, cs_n_s, fault_s});
      OFS_DEADTIME: rd_nxt = DATA_W'(deadtime_r);
      OFS_ICCTL: rd_nxt = DATA_W'(icctl_buf_r);
      default: begin
        for (int p = 0; p < NUM_PAIR; p++) begin
          if (hit(REG_ADDR, OFS_MOD0, p)) rd_nxt = DATA_W'(mod_r[p]);
          if (hit(REG_ADDR, OFS_CNT0, p)) rd_nxt = DATA_W'(cnt[p]);
        end
        for (int c = 0; c < NUM_CH; c++) begin
          if (hit(REG_ADDR, OFS_VAL0, c)) rd_nxt = DATA_W'(val_buf_r[c]);
        end
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      REG_RDATA <= '0;
    end else begin
      REG_RDATA <= REG_RD ? rd_nxt : '0;
    end
  end
endmodule

// ### mpc_motor_pwm_properties.sv
module mpc_motor_pwm_properties
  import mpc_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // register port
  input wire logic [mpc_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [mpc_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [mpc_pkg::DATA_W-1:0] REG_RDATA,
  // fault and status inputs
  input wire logic [mpc_pkg::NUM_FAULT-1:0] FAULT,
  input wire logic [mpc_pkg::NUM_PAIR-1:0] CURRENT_STATUS_N,
  // events
  input wire logic GLOBAL_LOAD_OK,
  input wire logic COMMUTATION_EVENT,
  // outputs
  input wire logic [mpc_pkg::NUM_CH-1:0] PWM_OUT
);
  logic [5:0] fen_r;
  logic [5:0] flvl_r;
  logic [5:0] icc_r;
  logic en_r;

  ////////////////////////////////////////////////////////////
  // shadow of written settings; only the buffer is mirrored, since reads return it
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      fen_r <= 6'h00;
      flvl_r <= 6'h00;
      icc_r <= 6'h00;
      en_r <= 1'b0;
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_FAULT) begin
        fen_r <= REG_WDATA[5:0];
        flvl_r <= REG_WDATA[13:8];
      end
      if (REG_ADDR == OFS_ICCTL) begin
        icc_r <= REG_WDATA[5:0];
      end
      if (REG_ADDR == OFS_CTRL) begin
        en_r <= REG_WDATA[CTRL_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  // reset forces both outputs quiet on the next edge
  a_reset_quiet: assert property (disable iff (1'b0) RESET |=> PWM_OUT == 6'h00 && REG_RDATA == 16'h0000)
    else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data outside read slot");
  a_icctl_read: assert property ($past(REG_RD) && $past(REG_ADDR) == OFS_ICCTL |-> REG_RDATA == {10'h000, icc_r})
    else $error("correction control readback wrong");
  a_unmapped_zero: assert property ($past(REG_RD) && $past(REG_ADDR) >= 8'h40 |-> REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  // sync latency is three edges, five samples leave margin
  a_fault_blank: assert property ((fen_r[0] && FAULT[0] && FAULT[5:4] == 2'b00) [*5] |-> PWM_OUT == 6'h00)
    else $error("fault 0 did not blank outputs");
  a_fault_force: assert property ((fen_r[4] && FAULT[4]) [*5] |-> PWM_OUT == flvl_r)
    else $error("fault 4 did not force level");
  a_disabled_quiet: assert property ((!en_r && FAULT[5:4] == 2'b00) [*5] |-> PWM_OUT == 6'h00)
    else $error("disabled block drives outputs");
  a_status_sync: assert property (REG_RD && REG_ADDR == OFS_STATUS && $stable(FAULT) && FAULT == $past(FAULT, 2)
    |=> REG_RDATA[5:0] == $past(FAULT))
    else $error("status fault bits wrong");
endmodule

bind mpc_motor_pwm mpc_motor_pwm_properties u_props (.CLOCK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
  .REG_RDATA, .FAULT, .CURRENT_STATUS_N, .GLOBAL_LOAD_OK, .COMMUTATION_EVENT, .PWM_OUT);

// ### mpc_gate_drive.sv
module mpc_gate_drive (
  // clock
  input wire logic clock,
  // commands from the bench and pwm drive
  input wire logic [5:0] pwm,
  input wire logic [5:0] fault_cmd,
  input wire logic comm_cmd,
  // lines into the block
  output logic [5:0] fault,
  output logic [2:0] cs_n,
  output logic comm_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] flt_r = 6'h00;
  logic [2:0] cs_r = 3'b111;
  logic ev_r = 1'b0;

  ////////////////////////////////////////////////////////////
  // protection reacts a cycle late, like a slow comparator
  always @(posedge clock) begin
    flt_r <= fault_cmd;
    ev_r <= comm_cmd;
    cs_r <= ~{pwm[4], pwm[2], pwm[0]}; // current flows while the top switch conducts
  end
  assign fault = flt_r;
  assign cs_n = cs_r;
  assign comm_evt = ev_r;
endmodule

// ### mpc_motor_pwm_bench.sv
module mpc_motor_pwm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mpc_pkg::*;
  `define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic GLOBAL_LOAD_OK = 1'b0;
  logic comm_cmd = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [15:0] REG_WDATA = 16'h0000;
  logic [15:0] REG_RDATA;
  logic [15:0] rd_val;
  logic [5:0] FAULT;
  logic [5:0] PWM_OUT;
  logic [5:0] fault_cmd = 6'h00;
  logic [2:0] CURRENT_STATUS_N;
  logic COMMUTATION_EVENT;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int hi;

  ////////////////////////////////////////////////////////////
  always #5 CLOCK = ~CLOCK;

  mpc_motor_pwm DUT (.CLOCK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .FAULT,
    .CURRENT_STATUS_N, .GLOBAL_LOAD_OK, .COMMUTATION_EVENT, .PWM_OUT);
  mpc_gate_drive u_gdu (.clock(CLOCK), .pwm(PWM_OUT), .fault_cmd, .comm_cmd, .fault(FAULT),
    .cs_n(CURRENT_STATUS_N), .comm_evt(COMMUTATION_EVENT));

  ////////////////////////////////////////////////////////////
  // one-cycle strobes; the closing edge leaves a gap so no strobe is assigned twice per step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] ex);
    rd(a, rd_val);
    `CHK(nm, ex, rd_val)
  endtask

  // high cycles of channel 0 over one 16-cycle period, any phase
  task automatic settle_meas(output int n);
    n = 0;
    repeat (40) @(posedge CLOCK);
    repeat (16) begin
      @(posedge CLOCK);
      #1 if (PWM_OUT[0] === 1'b1) n++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // the whole run needs well under a thousand cycles
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge CLOCK);
    RESET <= 1'b0;
    rchk("icctl", OFS_ICCTL, 16'h0000);
    wr(OFS_ICCTL, 16'hffff);
    rchk("icctl", OFS_ICCTL, 16'h003f);
    wr(8'hfe, 16'hffff);
    rchk("unmapped", 8'hfe, 16'h0000);
    wr(OFS_ICCTL, 16'h0000);
    rd(OFS_STATUS, rd_val);
    `CHK("cs", 3'b111, rd_val[8:6])
    // edge aligned complementary pair A, period 16
    wr(OFS_MOD0, 16'h000f);
    wr(OFS_VAL0, 16'h0003);
    wr(OFS_VAL0 + OFS_STEP, 16'h0009);
    wr(OFS_CTRL, 16'h0003);
    wr(OFS_LOAD, 16'h0001);
    settle_meas(hi);
    `CHK("width", 3, hi)
    // pulse edge bit waits for a load permit
    wr(OFS_ICCTL, 16'h0008);
    settle_meas(hi);
    `CHK("width", 3, hi)
    wr(OFS_LOAD, 16'h0001);
    settle_meas(hi);
    `CHK("width", 6, hi)
    // global permit selected for A clears it again
    wr(OFS_CTRL, 16'h0013);
    wr(OFS_ICCTL, 16'h0000);
    GLOBAL_LOAD_OK <= 1'b1;
    settle_meas(hi);
    `CHK("width", 3, hi)
    // mask held back until a commutation event
    wr(OFS_CTRL, 16'h001b);
    wr(OFS_MASK, 16'h003f);
    settle_meas(hi);
    `CHK("width", 3, hi)
    comm_cmd <= 1'b1;
    repeat (8) @(posedge CLOCK);
    comm_cmd <= 1'b0;
    settle_meas(hi);
    `CHK("width", 0, hi)
    wr(OFS_CTRL, 16'h0013);
    wr(OFS_MASK, 16'h0000);
    settle_meas(hi);
    `CHK("width", 3, hi)
    // software output takes channel 0 over
    wr(OFS_OUTCTL, 16'h0001);
    wr(OFS_SWOUT, 16'h0001);
    settle_meas(hi);
    `CHK("width", 16, hi)
    wr(OFS_OUTCTL, 16'h0000);
    // center aligned, period 16: count direction, then the polarity bit, picks the value
    wr(OFS_MOD0, 16'h0008);
    wr(OFS_VAL0 + OFS_STEP, 16'h0006);
    wr(OFS_CTRL, 16'h0017);
    settle_meas(hi);
    `CHK("width", 8, hi)
    wr(OFS_CTRL, 16'h0007);
    wr(OFS_ICCTL, 16'h0001);
    settle_meas(hi);
    `CHK("width", 5, hi)
    wr(OFS_CTRL, 16'h0087);
    settle_meas(hi);
    `CHK("width", 11, hi)
    // faults: blanking, status, forced level
    wr(OFS_FAULT, 16'h2a3f);
    fault_cmd <= 6'h01;
    repeat (10) @(posedge CLOCK);
    #1;
    `CHK("pwm", 6'h00, PWM_OUT)
    rd(OFS_STATUS, rd_val);
    `CHK("status", 6'h01, rd_val[5:0])
    fault_cmd <= 6'h10;
    repeat (10) @(posedge CLOCK);
    #1;
    `CHK("pwm", 6'h2a, PWM_OUT)
    fault_cmd <= 6'h00;
    // second reset in mid-run
    wr(OFS_ICCTL, 16'h0015);
    RESET <= 1'b1;
    repeat (3) @(posedge CLOCK);
    RESET <= 1'b0;
    rchk("icctl", OFS_ICCTL, 16'h0000);
    end_sim();
  end
endmodule
